/* interrupt_flag_enable_regs.sv */
// Interrupt flag word 4 and interrupt enable word 0 behind APB.
// Assumes event pulses and flag levels from logic on i_mclk.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module interrupt_flag_enable_regs (
   // Clock and reset
   input  wire logic                               i_mclk,
   input  wire logic                               i_sys_rst,
   // APB slave
   input  wire logic                               i_psel,
   input  wire logic                               i_penable,
   input  wire logic                               i_pwrite,
   input  wire logic [flag_enable_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [flag_enable_pkg::DATA_W-1:0] i_pwdata,
   input  wire logic [flag_enable_pkg::STRB_W-1:0] i_pstrb,
   output logic      [flag_enable_pkg::DATA_W-1:0] o_prdata,
   output logic                                    o_pready,
   output logic                                    o_pslverr,
   // Peripheral events for flag word 4
   input  wire logic [flag_enable_pkg::SRC4_W-1:0] i_flag4_event,
   input  wire logic [flag_enable_pkg::SRC4_W-1:0] i_word4_enable,
   // Flags of the sources gated by enable word 0
   input  wire logic [flag_enable_pkg::REG_W-1:0]  i_word0_flag,
   // Requests to the core
   output logic      [flag_enable_pkg::SRC4_W-1:0] o_req4,
   output logic      [flag_enable_pkg::REG_W-1:0]  o_req0,
   output logic                                    o_irq
);
   import flag_enable_pkg::*;

   // ==========================================================
   // Bus decode
   logic              setup;
   logic              access;
   logic              wr_access;
   logic              hit_flag4;
   logic              hit_en0;
   logic              hit_istat;
   logic              hit_imask;
   logic              mapped;
   logic [REG_W-1:0]  lane_mask;
   logic [REG_W-1:0]  wdata16;

   assign setup     = i_psel & ~i_penable;
   assign access    = i_psel & i_penable;
   assign wr_access = access & i_pwrite;
   assign hit_flag4 = (i_paddr == OFS_FLAG4);
   assign hit_en0   = (i_paddr == OFS_EN0);
   assign hit_istat = (i_paddr == OFS_ISTAT);
   assign hit_imask = (i_paddr == OFS_IMASK);
   assign mapped    = hit_flag4 | hit_en0 | hit_istat | hit_imask;
   assign wdata16   = i_pwdata[REG_W-1:0];

   // Byte lanes above the low halfword hold no storage
   assign lane_mask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

   // Zero wait states; a bad address is refused in the access phase
   assign o_pready  = 1'b1;

   // ==========================================================
   // Register storage
   logic [REG_W-1:0]  flag4_q;
   logic [REG_W-1:0]  en0_q;
   logic [REG_W-1:0]  istat_q;
   logic [REG_W-1:0]  imask_q;
   logic [REG_W-1:0]  flag4_wr;
   logic [REG_W-1:0]  istat_wr;
   logic [REG_W-1:0]  event16;
   logic              flag_write;
   logic              istat_write;

   assign flag_write  = wr_access & hit_flag4;
   assign istat_write = wr_access & hit_istat;
   assign flag4_wr    = flag_write ? lane_mask : REG_ZERO;
   assign istat_wr    = istat_write ? lane_mask : REG_ZERO;
   assign event16     = {8'h00, i_flag4_event};

   // Flag word 4: hardware set, software write of either value
   sticky_bit_bank #(
      .WIDTH     (REG_W),
      .IMPL      (FLAG4_IMPL),
      .CLEAR_ONE (1'b0)
   ) u_flag4 (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_set     (event16),
      .i_wr      (flag4_wr),
      .i_wdata   (wdata16),
      .o_bits    (flag4_q)
   );

   // Sticky interrupt status, cleared by writing one
   sticky_bit_bank #(
      .WIDTH     (REG_W),
      .IMPL      (FLAG4_IMPL),
      .CLEAR_ONE (1'b1)
   ) u_istat (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_set     (event16),
      .i_wr      (istat_wr),
      .i_wdata   (wdata16),
      .o_bits    (istat_q)
   );

   // Enable word 0
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         en0_q <= EN0_RST;
      end else if (wr_access && hit_en0) begin
         en0_q <= ((wdata16 & lane_mask) | (en0_q & ~lane_mask))
                  & EN0_IMPL;
      end
   end

   // Interrupt mask, same layout as flag word 4
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         imask_q <= IMASK_RST;
      end else if (wr_access && hit_imask) begin
         imask_q <= ((wdata16 & lane_mask) | (imask_q & ~lane_mask))
                    & FLAG4_IMPL;
      end
   end

   // ==========================================================
   // Read path, captured in the setup phase
   logic [REG_W-1:0]  rmux;
   logic              err_q;

   always_comb begin
      rmux = REG_ZERO;
      case (1'b1)
         hit_flag4: rmux = flag4_q;
         hit_en0:   rmux = en0_q;
         hit_istat: rmux = istat_q;
         hit_imask: rmux = imask_q;
         default:   rmux = REG_ZERO;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_prdata <= '0;
      end else if (setup) begin
         o_prdata <= {16'h0000, rmux};
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= ~mapped;
      end
   end

   assign o_pslverr = access & err_q;

   // ==========================================================
   // Requests to the core
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_req4 <= '0;
      end else begin
         o_req4 <= flag4_q[SRC4_W-1:0] & i_word4_enable;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_req0 <= '0;
      end else begin
         o_req0 <= i_word0_flag & en0_q;
      end
   end

   assign o_irq = |(istat_q & imask_q);

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   chk_flag_upper_zero : assert property (
      flag_write && i_pstrb[1] && i_pwdata[15:8] != 8'h00
      |=> flag4_q[15:8] == 8'h00)
      else $error("flag word upper byte not zero");

   chk_can_dma_set : assert property (
      (|i_flag4_event[POS_CAN_B_TX:POS_DMA_SIX])
      |=> (flag4_q[POS_CAN_B_TX:POS_DMA_SIX]
           & $past(i_flag4_event[POS_CAN_B_TX:POS_DMA_SIX]))
          == $past(i_flag4_event[POS_CAN_B_TX:POS_DMA_SIX]))
      else $error("CAN or DMA flag not set by event");

   chk_uart_flag_set : assert property (
      (|i_flag4_event[POS_UART_B_E:POS_UART_A_E])
      |=> (flag4_q[POS_UART_B_E:POS_UART_A_E]
           & $past(i_flag4_event[POS_UART_B_E:POS_UART_A_E]))
          == $past(i_flag4_event[POS_UART_B_E:POS_UART_A_E]))
      else $error("UART error flag not set by event");

   chk_hole_bits_zero : assert property (
      i_flag4_event[3] || i_flag4_event[0] || flag_write
      |=> !flag4_q[3] && !flag4_q[0])
      else $error("unimplemented flag bit not zero");

   chk_flag_after_rst : assert property (
      $past(i_sys_rst) |-> flag4_q == FLAG4_RST && en0_q == EN0_RST)
      else $error("register not zero after reset");

   chk_flag_write_val : assert property (
      flag_write && i_pstrb[0] && i_flag4_event == 8'h00
      |=> flag4_q[7:0] == ($past(i_pwdata[7:0]) & FLAG4_IMPL[7:0]))
      else $error("flag write not stored");

   // ==========================================================
   // Checks on enable word 0, the requests, flag word 4, the status and the mask
   chk_en_spare_zero : assert property (
      wr_access && hit_en0 && i_pstrb[1] && i_pwdata[15]
      |=> !en0_q[POS_EN0_SPARE] ##1 !en0_q[POS_EN0_SPARE])
      else $error("enable bit 15 not zero");

   chk_en_write_val : assert property (
      wr_access && hit_en0 && i_pstrb[1:0] == 2'b11
      |=> en0_q == ($past(i_pwdata[15:0]) & EN0_IMPL))
      else $error("enable write not stored");

   chk_en_lane_keep : assert property (
      wr_access && hit_en0 && !i_pstrb[1]
      |=> en0_q[15:8] == $past(en0_q[15:8]))
      else $error("enable byte changed with its strobe off");

   chk_read_capture : assert property (
      setup && hit_en0
      |=> o_prdata == {16'h0000, $past(en0_q)})
      else $error("read data not the enable word at setup");

   chk_req0_gate : assert property (
      ##1 o_req0 == ($past(i_word0_flag) & $past(en0_q)))
      else $error("word 0 request not flag and enable");

   chk_req4_gate : assert property (
      1'b1 |=> o_req4 == ($past(flag4_q[SRC4_W-1:0])
                          & $past(i_word4_enable)))
      else $error("word 4 request not flag and enable");

   chk_flag_sticky : assert property (
      !flag_write
      |=> (flag4_q & $past(flag4_q)) == $past(flag4_q))
      else $error("flag dropped without a write");

   chk_set_beats_clear : assert property (
      flag_write && i_pstrb[0] && !i_pwdata[POS_DMA_SEV]
      && i_flag4_event[POS_DMA_SEV]
      |=> flag4_q[POS_DMA_SEV] && istat_q[POS_DMA_SEV])
      else $error("event lost against a clear");

   chk_irq_follows : assert property (
      i_flag4_event[POS_CAN_A_TX] && imask_q[POS_CAN_A_TX]
      && $stable(imask_q)
      |=> o_irq)
      else $error("unmasked event did not raise irq");

   chk_status_set : assert property (
      (|(i_flag4_event & FLAG4_IMPL[7:0]))
      |=> (istat_q[7:0] & $past(i_flag4_event & FLAG4_IMPL[7:0]))
          == $past(i_flag4_event & FLAG4_IMPL[7:0]))
      else $error("status bit not set by event");

   chk_status_clear : assert property (
      istat_write && i_pstrb[0] && i_flag4_event == 8'h00
      |=> (istat_q[7:0] & $past(i_pwdata[7:0])) == 8'h00)
      else $error("status bit not cleared by writing one");

   chk_mask_write : assert property (
      wr_access && hit_imask && i_pstrb[0]
      |=> imask_q[7:0] == ($past(i_pwdata[7:0]) & FLAG4_IMPL[7:0]))
      else $error("mask write not stored");

   // ==========================================================
   // Checks on the bus answer
   chk_bad_addr : assert property (
      setup && !mapped ##1 access |-> o_pslverr && o_prdata == '0)
      else $error("unmapped access not refused");

   chk_slverr_mapped : assert property (
      setup && mapped ##1 access |-> !o_pslverr)
      else $error("mapped access refused");

   chk_unmapped_write : assert property (
      wr_access && !mapped
      |=> $stable(en0_q) && $stable(imask_q))
      else $error("unmapped write changed a register");

endmodule

/* flag_enable_pkg.sv */
// Constants for the interrupt flag and enable register block.
// Assumes a 32-bit APB register bus and one system clock.
package flag_enable_pkg;

   // =========================================================
   // Widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned REG_W  = 16;
   localparam int unsigned STRB_W = 4;

   // =========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_FLAG4 = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_EN0   = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_ISTAT = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_IMASK = 12'h00c;

   // =========================================================
   // Implemented bits and values after reset
   localparam logic [REG_W-1:0] FLAG4_IMPL = 16'h00f6;
   localparam logic [REG_W-1:0] EN0_IMPL   = 16'h7fff;
   localparam logic [REG_W-1:0] FLAG4_RST  = 16'h0000;
   localparam logic [REG_W-1:0] EN0_RST    = 16'h0000;
   localparam logic [REG_W-1:0] IMASK_RST  = 16'h0000;
   localparam logic [REG_W-1:0] REG_ZERO   = 16'h0000;

   // =========================================================
   // Flag word 4 bit positions
   localparam int unsigned POS_CAN_B_TX = 7;
   localparam int unsigned POS_CAN_A_TX = 6;
   localparam int unsigned POS_DMA_SEV  = 5;
   localparam int unsigned POS_DMA_SIX  = 4;
   localparam int unsigned POS_UART_B_E = 2;
   localparam int unsigned POS_UART_A_E = 1;
   localparam int unsigned SRC4_W       = 8;

   // Enable word 0 positions of the first and last sources and of the spare bit
   localparam int unsigned POS_DMA_ONE_EN = 14;
   localparam int unsigned POS_EXT_ZERO_EN = 0;
   localparam int unsigned POS_EN0_SPARE  = 15;

endpackage

/* sticky_bit_bank.sv */
// Bank of sticky bits: hardware sets, software writes or clears.
// Assumes set pulses and writes come from logic on the same clock.
`timescale 1ns/10ps
module sticky_bit_bank #(
   parameter int unsigned          WIDTH     = 16,
   parameter logic [WIDTH-1:0]     IMPL      = '1,
   parameter bit                   CLEAR_ONE = 1'b0
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   // Hardware set and software write
   input  wire logic [WIDTH-1:0] i_set,
   input  wire logic [WIDTH-1:0] i_wr,
   input  wire logic [WIDTH-1:0] i_wdata,
   // Stored bits
   output logic      [WIDTH-1:0] o_bits
);

   // ==========================================================
   // Per-bit storage
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         if (IMPL[g]) begin : g_impl
            always_ff @(posedge i_mclk) begin
               if (i_sys_rst) begin
                  o_bits[g] <= 1'b0;
               end else if (i_set[g]) begin
                  // A set in the same cycle as a clear wins
                  o_bits[g] <= 1'b1;
               end else if (i_wr[g]) begin
                  if (CLEAR_ONE) begin
                     o_bits[g] <= o_bits[g] & ~i_wdata[g];
                  end else begin
                     o_bits[g] <= i_wdata[g];
                  end
               end
            end
         end else begin : g_hole
            assign o_bits[g] = 1'b0;
         end
      end
   endgenerate

endmodule

/* peripheral_model.sv */
// Peripheral event sources and level flags facing the register block.
// Assumes tasks are called right after a rising edge of i_mclk.
`timescale 1ns/10ps
module peripheral_model (
   // Clock
   input  wire logic                               i_mclk,
   // Source signals
   output logic      [flag_enable_pkg::SRC4_W-1:0] o_flag4_event,
   output logic      [flag_enable_pkg::SRC4_W-1:0] o_word4_enable,
   output logic      [flag_enable_pkg::REG_W-1:0]  o_word0_flag
);
   import flag_enable_pkg::*;
   initial begin
      o_flag4_event  = '0;
      o_word4_enable = '0;
      o_word0_flag   = '0;
   end
   // =========================================================
   // One-cycle event on a single source
   task automatic pulse(input int idx);
      o_flag4_event <= SRC4_W'(1) << idx;
      @(posedge i_mclk);
      o_flag4_event <= '0;
   endtask
   task automatic levels(input logic [SRC4_W-1:0] en4,
                         input logic [REG_W-1:0]  fl0);
      o_word4_enable <= en4;
      o_word0_flag   <= fl0;
   endtask
endmodule

/* testbench.sv */
// Self-checking bench for the flag and enable register block.
// Assumes zero wait state APB and the peripheral model beside it.
`timescale 1ns/10ps
module testbench;
   import flag_enable_pkg::*;
   logic              i_mclk, i_sys_rst, psel, penable, pwrite, pready;
   logic              pslverr, irq, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd, exp;
   logic [STRB_W-1:0] pstrb;
   logic [SRC4_W-1:0] ev4, en4, req4;
   logic [REG_W-1:0]  fl0, req0;
   int                errors, checks_done;

   interrupt_flag_enable_regs u_interrupt_flag_enable_regs (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_flag4_event(ev4),
      .i_word4_enable(en4), .i_word0_flag(fl0), .o_req4(req4),
      .o_req0(req0), .o_irq(irq));
   peripheral_model u_peripheral_model (
      .i_mclk(i_mclk), .o_flag4_event(ev4), .o_word4_enable(en4),
      .o_word0_flag(fl0));

   always #2 i_mclk = ~i_mclk;

   // =========================================================
   // Tasks
   task automatic finish_test();
      if (errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input logic [DATA_W-1:0] got, e, input string what);
      checks_done++;
      if (got !== e) begin
         errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, e);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge i_mclk);
      penable <= 1'b1;
      @(posedge i_mclk);
      while (pready !== 1'b1) @(posedge i_mclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [STRB_W-1:0] s);
      apb(1'b1, a, d, s);
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e, input string what);
      apb(1'b0, a, '0, 4'hf);
      cmp(rd, e, what);
   endtask

   // =========================================================
   // Tests
   initial begin
      #20000;
      errors++;
      finish_test();
   end
   initial begin
      i_mclk = 1'b0;
      i_sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      repeat (5) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      rdchk(OFS_FLAG4, 32'h0, "flag4 reset");
      rdchk(OFS_EN0, 32'h0, "en0 reset");
      rdchk(OFS_IMASK, 32'h0, "mask reset");
      rdchk(OFS_ISTAT, 32'h0, "status reset");
      cmp(DATA_W'(err), 32'h0, "mapped error");
      wr(OFS_FLAG4, 32'hffff_ffff, 4'hf);
      rdchk(OFS_FLAG4, 32'h0000_00f6, "flag4 bits");
      wr(OFS_FLAG4, 32'h0, 4'hf);
      rdchk(OFS_FLAG4, 32'h0, "flag4 clear");
      wr(OFS_EN0, 32'hffff_ffff, 4'h1);
      rdchk(OFS_EN0, 32'h0000_00ff, "en0 lane");
      wr(OFS_EN0, 32'hffff_ffff, 4'hf);
      rdchk(OFS_EN0, 32'h0000_7fff, "en0 bits");
      // Requests gated by enable word 0
      u_peripheral_model.levels(8'hff, 16'hffff);
      repeat (2) @(posedge i_mclk);
      cmp(DATA_W'(req0), 32'h7fff, "req0 all");
      wr(OFS_EN0, 32'h0000_4009, 4'hf);
      repeat (2) @(posedge i_mclk);
      cmp(DATA_W'(req0), 32'h4009, "req0 some");
      // Interrupt status, mask and clear
      u_peripheral_model.pulse(POS_CAN_A_TX);
      @(posedge i_mclk);
      cmp(DATA_W'(irq), 32'h0, "irq masked");
      wr(OFS_IMASK, 32'h40, 4'hf);
      cmp(DATA_W'(irq), 32'h1, "irq raised");
      rdchk(OFS_ISTAT, 32'h40, "status set");
      wr(OFS_ISTAT, 32'h40, 4'hf);
      cmp(DATA_W'(irq), 32'h0, "irq cleared");
      rdchk(OFS_ISTAT, 32'h0, "status clear");
      rdchk(OFS_FLAG4, 32'h40, "flag sticks");
      wr(OFS_FLAG4, 32'h0, 4'hf);
      // Every event source of flag word 4
      for (int i = 0; i < SRC4_W; i++) begin
         exp = DATA_W'((8'h01 << i) & FLAG4_IMPL[7:0]);
         u_peripheral_model.pulse(i);
         repeat (2) @(posedge i_mclk);
         cmp(DATA_W'(req4), exp, "req4 event");
         rdchk(OFS_FLAG4, exp, "flag4 event");
         wr(OFS_FLAG4, 32'h0, 4'hf);
      end
      // Event against a clear in the same cycle; enables gate requests
      u_peripheral_model.levels(8'h0f, 16'h0000);
      fork
         wr(OFS_FLAG4, 32'h0, 4'hf);
         begin
            @(posedge i_mclk);
            u_peripheral_model.pulse(POS_DMA_SEV);
         end
      join
      rdchk(OFS_FLAG4, 32'h20, "set beats clear");
      cmp(DATA_W'(req4), 32'h0, "req4 enable off");
      cmp(DATA_W'(req0), 32'h0, "req0 flag off");
      // Unmapped address
      apb(1'b1, 12'h010, 32'h0000_ffff, 4'hf);
      cmp(DATA_W'(err), 32'h1, "unmapped write error");
      rdchk(OFS_EN0, 32'h0000_4009, "unmapped write ignored");
      apb(1'b0, 12'h010, '0, 4'hf);
      cmp(rd, 32'h0, "unmapped data");
      cmp(DATA_W'(err), 32'h1, "unmapped error");
      finish_test();
   end
endmodule
